// >>> core/dtc_defs.vh
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// register addresses on the special function register port
`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE    8'h89
`define DTC_ADDR_LOW0    8'h8A
`define DTC_ADDR_LOW1    8'h8B
`define DTC_ADDR_HIGH0   8'h8C
`define DTC_ADDR_HIGH1   8'h8D

// control register fields
`define DTC_CTL_RUN0     4
`define DTC_CTL_FLAG0    5
`define DTC_CTL_RUN1     6
`define DTC_CTL_FLAG1    7

// mode register: nibble base per timer, bits within nibble
`define DTC_MOD_BASE0    0
`define DTC_MOD_BASE1    4
`define DTC_MOD_MODE_LO  0
`define DTC_MOD_SRC      2
`define DTC_MOD_GATE     3

// operating modes
`define DTC_MODE_13BIT   2'h0
`define DTC_MODE_16BIT   2'h1
`define DTC_MODE_RELOAD  2'h2
`define DTC_MODE_SPLIT   2'h3

// reset values
`define DTC_RST_BYTE     8'h00

// timing
`define DTC_CLK_PERIOD_NS  20
`define DTC_PER_CYCLE_CLKS 6
`define DTC_PER_LAST_TICK  3'h5
`define DTC_PRESCALE_MASK  8'h1F

`endif

// >>> core/dtc_timer_pair.v
`timescale 1ns/1ps
`include "dtc_defs.vh"

module dtc_timer_pair (
	// clock, reset, enable
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       clk_en,
	// special function register port
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	output reg  [7:0] sfr_rdata,
	// external pins
	input  wire       count_pin_first,
	input  wire       count_pin_second,
	input  wire       gate_pin_first,
	input  wire       gate_pin_second,
	// interrupt vector acknowledge from core
	input  wire       irq_ack_first,
	input  wire       irq_ack_second,
	// overflow interrupt requests
	output wire       irq_first,
	output wire       irq_second,
	// control bits kept for the external interrupt logic
	output wire [3:0] ext_irq_ctl
);

	// ****************************************
	// peripheral cycle divider
	// ****************************************
	localparam [2:0] PER_LAST = `DTC_PER_LAST_TICK;

	reg  [2:0] per_cnt;
	wire       per_tick = (per_cnt == PER_LAST);

	always @(posedge sys_clk) begin
		if (rst)
			per_cnt <= 3'h0;
		else if (clk_en)
			per_cnt <= per_tick ? 3'h0 : per_cnt + 3'h1;
	end

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0] timer_control_register;
	reg  [7:0] timer_mode_register;
	reg  [7:0] count_low_byte  [0:1];
	reg  [7:0] count_high_byte [0:1];

	wire [1:0] run_bit;
	wire [1:0] src_sel;
	wire [1:0] gate_en;
	wire [1:0] mode0;
	wire [1:0] mode1;
	wire [1:0] pin_sync;
	wire [1:0] gate_sync;

	assign run_bit[0] = timer_control_register[`DTC_CTL_RUN0];
	assign run_bit[1] = timer_control_register[`DTC_CTL_RUN1];
	assign mode0   = timer_mode_register[`DTC_MOD_BASE0 +: 2];
	assign mode1   = timer_mode_register[`DTC_MOD_BASE1 +: 2];
	assign src_sel = {timer_mode_register[`DTC_MOD_BASE1 + `DTC_MOD_SRC],
		timer_mode_register[`DTC_MOD_BASE0 + `DTC_MOD_SRC]};
	assign gate_en = {timer_mode_register[`DTC_MOD_BASE1 + `DTC_MOD_GATE],
		timer_mode_register[`DTC_MOD_BASE0 + `DTC_MOD_GATE]};
	assign ext_irq_ctl = {timer_control_register[3:2], timer_control_register[1:0]};

	// ****************************************
	// pin synchronisers and edge sampling
	// ****************************************
	reg  [1:0] cnt_meta;
	reg  [1:0] cnt_sync;
	reg  [1:0] gt_meta;
	reg  [1:0] gt_sync;
	reg  [1:0] sample_now;
	reg  [1:0] sample_prev;

	always @(posedge sys_clk) begin
		if (rst) begin
			cnt_meta    <= 2'h0;
			cnt_sync    <= 2'h0;
			gt_meta     <= 2'h0;
			gt_sync     <= 2'h0;
			sample_now  <= 2'h0;
			sample_prev <= 2'h0;
		end else if (clk_en) begin
			cnt_meta <= {count_pin_second, count_pin_first};
			cnt_sync <= cnt_meta;
			gt_meta  <= {gate_pin_second, gate_pin_first};
			gt_sync  <= gt_meta;
			if (per_tick) begin
				sample_now  <= cnt_sync;
				sample_prev <= sample_now;
			end
		end
	end

	assign pin_sync  = cnt_sync;
	assign gate_sync = gt_sync;

	// ****************************************
	// count enables per timer
	// ****************************************
	// falls seen on the last tick, counted on the next one
	reg  [1:0] fall_pending;
	wire [1:0] fall_tick;
	wire [1:0] enable;
	wire [1:0] inc;
	wire       t0_split = (mode0 == `DTC_MODE_SPLIT);
	wire       t1_halt  = (mode1 == `DTC_MODE_SPLIT);

	// one increment per recognised edge, issued on the following tick
	always @(posedge sys_clk) begin
		if (rst)
			fall_pending <= 2'h0;
		else if (clk_en && per_tick)
			fall_pending <= sample_now & ~cnt_sync;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_en
			assign fall_tick[gi] = per_tick & fall_pending[gi];
			assign enable[gi] = run_bit[gi] & (~gate_en[gi] | gate_sync[gi]);
			assign inc[gi] = enable[gi] & (src_sel[gi] ? fall_tick[gi] : per_tick);
		end
	endgenerate

	// gate pin only matters while the gate bit is set

	// split-mode high byte of timer 0 runs on timer 1 run bit, clock/6
	wire split_hi_inc = t0_split & run_bit[1] & per_tick;

	// ****************************************
	// counters
	// ****************************************
	reg  [7:0] next_low  [0:1];
	reg  [7:0] next_high [0:1];
	reg  [1:0] ovf;
	reg  [1:0] mode_x    [0:1];
	reg        low_ovf;
	reg        pre_ovf;
	integer    k;

	always @* begin
		mode_x[0] = mode0;
		mode_x[1] = mode1;
		ovf = 2'h0;
		low_ovf = 1'b0;
		pre_ovf = 1'b0;
		for (k = 0; k < 2; k = k + 1) begin
			next_low[k]  = count_low_byte[k];
			next_high[k] = count_high_byte[k];
			if (inc[k] && !(k == 1 && t1_halt)) begin
				case (mode_x[k])
				`DTC_MODE_13BIT: begin
					pre_ovf = (count_low_byte[k][4:0] == 5'h1F);
					next_low[k] = (count_low_byte[k] & ~`DTC_PRESCALE_MASK) |
						((count_low_byte[k] + 8'h01) & `DTC_PRESCALE_MASK);
					if (pre_ovf) begin
						next_high[k] = count_high_byte[k] + 8'h01;
						ovf[k] = (count_high_byte[k] == 8'hFF);
					end
				end
				`DTC_MODE_16BIT: begin
					low_ovf = (count_low_byte[k] == 8'hFF);
					next_low[k] = count_low_byte[k] + 8'h01;
					if (low_ovf) begin
						next_high[k] = count_high_byte[k] + 8'h01;
						ovf[k] = (count_high_byte[k] == 8'hFF);
					end
				end
				`DTC_MODE_RELOAD: begin
					if (count_low_byte[k] == 8'hFF) begin
						next_low[k] = count_high_byte[k];
						ovf[k] = 1'b1;
					end else
						next_low[k] = count_low_byte[k] + 8'h01;
				end
				`DTC_MODE_SPLIT: begin
					next_low[k] = count_low_byte[k] + 8'h01;
					ovf[k] = (count_low_byte[k] == 8'hFF);
				end
				default: next_low[k] = count_low_byte[k];
				endcase
			end
		end
		if (split_hi_inc) begin
			next_high[0] = count_high_byte[0] + 8'h01;
			if (count_high_byte[0] == 8'hFF)
				ovf[1] = 1'b1;
		end
	end

	// ****************************************
	// register writes and flags
	// ****************************************
	// hardware set comes last so it beats ack and write
	reg  [7:0] next_ctl;

	always @* begin
		next_ctl = timer_control_register;
		if (sfr_wr && sfr_addr == `DTC_ADDR_CONTROL)
			next_ctl = sfr_wdata;
		if (irq_ack_first)
			next_ctl[`DTC_CTL_FLAG0] = 1'b0;
		if (irq_ack_second)
			next_ctl[`DTC_CTL_FLAG1] = 1'b0;
		if (ovf[0])
			next_ctl[`DTC_CTL_FLAG0] = 1'b1;
		if (ovf[1])
			next_ctl[`DTC_CTL_FLAG1] = 1'b1;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			timer_control_register <= `DTC_RST_BYTE;
			timer_mode_register    <= `DTC_RST_BYTE;
			count_low_byte[0]      <= `DTC_RST_BYTE;
			count_low_byte[1]      <= `DTC_RST_BYTE;
			count_high_byte[0]     <= `DTC_RST_BYTE;
			count_high_byte[1]     <= `DTC_RST_BYTE;
		end else if (clk_en) begin
			timer_control_register <= next_ctl;
			if (sfr_wr && sfr_addr == `DTC_ADDR_MODE)
				timer_mode_register <= sfr_wdata;
			count_low_byte[0]  <= (sfr_wr && sfr_addr == `DTC_ADDR_LOW0)
				? sfr_wdata : next_low[0];
			count_low_byte[1]  <= (sfr_wr && sfr_addr == `DTC_ADDR_LOW1)
				? sfr_wdata : next_low[1];
			count_high_byte[0] <= (sfr_wr && sfr_addr == `DTC_ADDR_HIGH0)
				? sfr_wdata : next_high[0];
			count_high_byte[1] <= (sfr_wr && sfr_addr == `DTC_ADDR_HIGH1)
				? sfr_wdata : next_high[1];
		end
	end

	assign irq_first  = timer_control_register[`DTC_CTL_FLAG0];
	assign irq_second = timer_control_register[`DTC_CTL_FLAG1];

	// ****************************************
	// read port
	// ****************************************
	always @(posedge sys_clk) begin
		if (rst)
			sfr_rdata <= 8'h00;
		else if (clk_en) begin
			if (sfr_rd) begin
				case (sfr_addr)
				`DTC_ADDR_CONTROL: sfr_rdata <= timer_control_register;
				`DTC_ADDR_MODE:    sfr_rdata <= timer_mode_register;
				`DTC_ADDR_LOW0:    sfr_rdata <= count_low_byte[0];
				`DTC_ADDR_LOW1:    sfr_rdata <= count_low_byte[1];
				`DTC_ADDR_HIGH0:   sfr_rdata <= count_high_byte[0];
				`DTC_ADDR_HIGH1:   sfr_rdata <= count_high_byte[1];
				default:           sfr_rdata <= 8'h00;
				endcase
			end else
				sfr_rdata <= 8'h00;
		end
	end

endmodule

// >>> dv/dtc_timer_pair_assertions.sv
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_timer_pair_assertions (
	// clock and reset
	input wire       sys_clk,
	input wire       rst,
	input wire       clk_en,
	// register port
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire [7:0] sfr_rdata,
	// flags and stored bits
	input wire       irq_first,
	input wire       irq_second,
	input wire [3:0] ext_irq_ctl
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire cw = clk_en && sfr_wr && sfr_addr == `DTC_ADDR_CONTROL;
	wire cr = clk_en && sfr_rd && sfr_addr == `DTC_ADDR_CONTROL;
	wire mw = clk_en && sfr_wr && sfr_addr == `DTC_ADDR_MODE;
	wire mr = clk_en && sfr_rd && sfr_addr == `DTC_ADDR_MODE;
	wire um = clk_en && sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8D);
	AST_CTL_ECHO: assert property (cw |=> ext_irq_ctl == $past(sfr_wdata[3:0]))
		else $error("stored control bits differ");
	AST_FLAG0_SET: assert property (cw && sfr_wdata[5] |=> irq_first)
		else $error("timer 0 flag not set");
	AST_FLAG1_SET: assert property (cw && sfr_wdata[7] |=> irq_second)
		else $error("timer 1 flag not set");
	AST_CTL_READ: assert property (cr |=> sfr_rdata[7] == $past(irq_second)
		&& sfr_rdata[5] == $past(irq_first) && sfr_rdata[3:0] == $past(ext_irq_ctl))
		else $error("control read wrong");
	AST_MODE_ECHO: assert property (mw ##2 mr |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("mode read wrong");
	AST_UNMAPPED: assert property (um |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_IDLE: assert property (clk_en && !sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data without read");
	AST_FREEZE: assert property (!clk_en |=> $stable(irq_first) && $stable(irq_second))
		else $error("flags moved while frozen");
endmodule

// >>> dv/dtc_pin_src.sv
`timescale 1ns/1ps
module dtc_pin_src (
	// clock
	input wire       sys_clk,
	// burst request
	input wire       go,
	input wire [7:0] pulses,
	// count pin
	output reg       pin
);
	reg [8:0] n = 9'h000;
	reg [2:0] k = 3'h0;
	initial pin = 1'b1;
	// each level held one peripheral cycle
	always @(posedge sys_clk) begin
		if (go)
			n <= {pulses, 1'b0};
		else if (n != 9'h000) begin
			k <= (k == 3'h5) ? 3'h0 : k + 3'h1;
			if (k == 3'h5) begin
				pin <= ~pin;
				n <= n - 9'h001;
			end
		end
	end
endmodule

// >>> dv/tb_dtc_timer_pair.sv
`timescale 1ns/1ps
`include "dtc_defs.vh"
module tb_dtc_timer_pair;
	localparam [7:0] CT = `DTC_ADDR_CONTROL;
	localparam [7:0] MD = `DTC_ADDR_MODE;
	localparam [7:0] L0 = `DTC_ADDR_LOW0;
	localparam [7:0] L1 = `DTC_ADDR_LOW1;
	localparam [7:0] H0 = `DTC_ADDR_HIGH0;
	localparam [7:0] H1 = `DTC_ADDR_HIGH1;
	reg        sys_clk = 1'b0;
	reg        rst = 1'b1;
	reg        clk_en = 1'b1;
	reg  [7:0] sfr_addr = 8'h00;
	reg  [7:0] sfr_wdata = 8'h00;
	reg        sfr_wr = 1'b0;
	reg        sfr_rd = 1'b0;
	reg        gate_pin_first = 1'b0;
	reg        irq_ack_first = 1'b0;
	reg        go = 1'b0;
	reg  [7:0] pulses = 8'h00;
	reg  [7:0] v, h, r;
	wire [7:0] sfr_rdata;
	wire       cpin, irq_first, irq_second;
	int        fail_count = 0;
	int        comparisons = 0;
	always #10 sys_clk = ~sys_clk;
	dtc_timer_pair dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.count_pin_first(cpin), .count_pin_second(1'b1), .gate_pin_first(gate_pin_first),
		.gate_pin_second(1'b1), .irq_ack_first(irq_ack_first), .irq_ack_second(1'b0),
		.irq_first(irq_first), .irq_second(irq_second), .ext_irq_ctl());
	dtc_pin_src src_u (.sys_clk(sys_clk), .go(go), .pulses(pulses), .pin(cpin));
	task automatic complete_run;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input [7:0] seen, input [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		cyc(1);
		sfr_wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input [7:0] a);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		cyc(1);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
		cyc(1);
	endtask
	task automatic rc(input [7:0] a, input [7:0] e, input string what);
		rd(a);
		chk(v, e, what);
	endtask
	// read until the byte moves away from old
	task automatic poll(input [7:0] a, input [7:0] old);
		for (int i = 0; i < 100; i++) begin
			rd(a);
			if (v !== old) break;
		end
	endtask
	task automatic wflag(input bit sel);
		for (int i = 0; i < 2000; i++) begin
			#1;
			if ((sel ? irq_second : irq_first) === 1'b1) break;
			cyc(1);
		end
		chk({7'h00, sel ? irq_second : irq_first}, 8'h01, "overflow flag");
		cyc(1);
	endtask
	initial begin
		void'($urandom(32'hDBC4));
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		for (int a = 8'h87; a <= 8'h8D; a++) rc(8'(a), 8'h00, "reset value");
		h = 8'($urandom_range(254));
		wr(L0, 8'hFF);
		wr(H0, h);
		wr(CT, 8'h10);
		poll(H0, h);
		wr(CT, 8'h00);
		rc(H0, h + 8'h01, "mode0 high");
		rc(L0, 8'hE0, "mode0 low");
		wr(MD, 8'h01);
		wr(L0, 8'hFE);
		wr(H0, 8'hFF);
		wr(CT, 8'h10);
		wflag(0);
		irq_ack_first <= 1'b1;
		cyc(1);
		irq_ack_first <= 1'b0;
		cyc(1);
		#1 chk({7'h00, irq_first}, 8'h00, "flag after ack");
		cyc(1);
		wr(CT, 8'h00);
		rc(H0, 8'h00, "mode1 high");
		r = 8'hA0 | 8'($urandom_range(15));
		wr(CT, r);
		rc(CT, r, "control");
		wr(CT, 8'h00);
		r = 8'hE0 | 8'($urandom_range(15));
		h = 8'hE0 | 8'($urandom_range(15));
		wr(MD, 8'h20);
		wr(H1, r);
		wr(L1, 8'hFF);
		wr(CT, 8'h40);
		wflag(1);
		wr(H1, h);
		wr(CT, 8'h40);
		wflag(1);
		wr(CT, 8'h00);
		rc(H1, h, "reload value");
		rc(L1, h, "reloaded low");
		wr(MD, 8'h09);
		wr(L0, 8'h00);
		wr(CT, 8'h10);
		cyc(40);
		rc(L0, 8'h00, "gated low");
		gate_pin_first <= 1'b1;
		poll(L0, 8'h00);
		chk(v, 8'h01, "ungated low");
		wr(CT, 8'h00);
		wr(MD, 8'h05);
		rc(MD, 8'h05, "mode");
		wr(L0, 8'h00);
		wr(CT, 8'h10);
		pulses <= 8'($urandom_range(40, 1));
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(600);
		wr(CT, 8'h00);
		rc(L0, pulses, "edge count");
		wr(MD, 8'h33);
		wr(H0, 8'hFF);
		wr(L1, 8'h55);
		clk_en <= 1'b0;
		cyc(8);
		clk_en <= 1'b1;
		wr(CT, 8'h40);
		wflag(1);
		chk({7'h00, irq_first}, 8'h00, "timer0 flag");
		wr(CT, 8'h00);
		rc(L1, 8'h55, "halted timer1");
		complete_run;
	end
	initial begin
		cyc(20000);
		fail_count++;
		complete_run;
	end
endmodule
bind dtc_timer_pair dtc_timer_pair_assertions chk_u (.sys_clk(sys_clk), .rst(rst),
	.clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq_first(irq_first),
	.irq_second(irq_second), .ext_irq_ctl(ext_irq_ctl));
